// file: verilog/pbm_pkg.sv
// holds register offsets, field positions, reset values and timing counts
// for the basic mode control register bank; used by the event latch and bank design files.
package pbm_pkg;
    // ***************************************************************
    // clock and timing
    // ***************************************************************
    localparam int CLK_HZ           = 40000000;   // device clock rate
    localparam int RST_TIME_NS      = 1000;       // software reset length
    localparam int RST_CYCLES       = (RST_TIME_NS * (CLK_HZ / 1000000)
                                      + 999) / 1000;
    localparam int LOOP_DEAD_US     = 500;        // loopback dead time
    localparam int LOOP_DEAD_CYCLES = LOOP_DEAD_US * (CLK_HZ / 1000000);

    // ***************************************************************
    // register map (word addresses on the avalon bus)
    // ***************************************************************
    localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;  // basic_mode_control
    localparam logic [3:0] ADDR_EVENTS    = 4'h1;  // event status bits
    localparam logic [3:0] ADDR_STATE     = 4'h2;  // live port state

    // ***************************************************************
    // basic_mode_control field positions
    // ***************************************************************
    localparam int BIT_RESET    = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_SPEED    = 13;
    localparam int BIT_AN_EN    = 12;
    localparam int BIT_DUPLEX   = 8;

    // ***************************************************************
    // event register field positions
    // ***************************************************************
    localparam int BIT_EV_SELF_CLEAR = 0;   // self_clearing
    localparam int BIT_EV_READ_CLEAR = 1;   // read_only_read_clears
    localparam int BIT_EV_LATCH_ZERO = 2;   // latch_zero_until_read
    localparam int BIT_EV_LATCH_ONE  = 3;   // latch_one_until_read
    localparam int BIT_EV_FIXED      = 4;   // fixed_read_only

    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [15:0] FIXED_VALUE     = 16'h0010; // fixed bit set
    localparam logic        LATCH_ZERO_INIT = 1'b1;
    localparam logic [15:0] READ_ZERO       = 16'h0000;
endpackage

// file: verilog/pbm_bus_if.sv
// interface between the register bank and its event latch module.
// assumes both ends sit on the one device clock.
`timescale 1ns/1ps
interface pbm_bus_if;
    logic       read_events;   // one-cycle pulse: event word was read
    logic [4:0] event_word;    // current event status bits

    modport bank  (output read_events, input  event_word);
    modport latch (input  read_events, output event_word);
endinterface

// file: verilog/pbm_event_latch.sv
// holds the generic access-type event bits of the register bank.
// assumes event inputs are synchronous to mclk_i.
`timescale 1ns/1ps
module pbm_event_latch (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // event sources
    input  wire logic ev_level_i,
    input  wire logic ev_count_i,
    input  wire logic ev_low_i,
    input  wire logic ev_high_i,
    // bank side
    pbm_bus_if.latch  bus
);
    logic rdc_reg;     // read-clears bit
    logic rdc_next;
    logic llo_reg;     // latch-zero bit
    logic llo_next;
    logic lhi_reg;     // latch-one bit
    logic lhi_next;
    logic lvl_reg;     // self-clearing bit
    logic lvl_next;

    // ***************************************************************
    // next state; an event in the read cycle wins over the clear
    // ***************************************************************
    always_comb begin
        lvl_next = ev_level_i;
        rdc_next = bus.read_events ? 1'b0 : rdc_reg;
        if (ev_count_i) begin
            rdc_next = 1'b1;
        end
        llo_next = bus.read_events ? 1'b1 : llo_reg;
        if (ev_low_i) begin
            llo_next = 1'b0;
        end
        lhi_next = bus.read_events ? 1'b0 : lhi_reg;
        if (ev_high_i) begin
            lhi_next = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lvl_reg <= 1'b0;
            rdc_reg <= 1'b0;
            llo_reg <= pbm_pkg::LATCH_ZERO_INIT;
            lhi_reg <= 1'b0;
        end else begin
            lvl_reg <= lvl_next;
            rdc_reg <= rdc_next;
            llo_reg <= llo_next;
            lhi_reg <= lhi_next;
        end
    end

    assign bus.event_word = {pbm_pkg::FIXED_VALUE[pbm_pkg::BIT_EV_FIXED],
                             lhi_reg, llo_reg, rdc_reg, lvl_reg};
endmodule

// file: verilog/pbm_mode_ctrl.sv
// basic mode control register bank of one transceiver port, reached
// over avalon-mm; straps and event inputs assumed synchronous.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps

// Contract
// - writing reset bit resets, self-clears when done
// - reset completion reloads strap configuration
// - loopback bit routes transmit into receive
// - loopback may give 500 us dead time
// - speed bit: one 100, zero 10
// - auto-negotiation enable initialised from strap
// - fiber mode forces auto-negotiation off (here only when straps load; a write of bit 12 can still set it)
// - auto-negotiation on ignores speed, duplex bits
// - self-clearing bit follows its event
// - read-clears bit cleared by read
// - latch-zero bit holds until read
// - latch-one bit holds until read
// - fixed bit ignores writes
// - auto-negotiation off uses speed, duplex bits
// - duplex bit: one full, zero half
module pbm_mode_ctrl #(
    parameter int RST_CYCLES       = pbm_pkg::RST_CYCLES,
    parameter int LOOP_DEAD_CYCLES = pbm_pkg::LOOP_DEAD_CYCLES
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // straps
    input  wire logic        strap_speed_i,
    input  wire logic        strap_an_en_i,
    input  wire logic        strap_duplex_i,
    input  wire logic        fiber_mode_enable_i,
    // event inputs
    input  wire logic        ev_level_i,
    input  wire logic        ev_count_i,
    input  wire logic        ev_low_i,
    input  wire logic        ev_high_i,
    // port control outputs
    output logic             loopback_o,
    output logic             speed_100_o,
    output logic             full_duplex_o,
    output logic             an_enable_o,
    output logic             soft_reset_o,
    output logic             loop_dead_o
);
    // ***************************************************************
    // elaboration checks
    // ***************************************************************
    if (RST_CYCLES < 1 || RST_CYCLES > 65535) begin : g_chk_rst
        $error("reset length out of range");
    end
    if (LOOP_DEAD_CYCLES < 1 || LOOP_DEAD_CYCLES > 65535) begin : g_chk_dead
        $error("dead time out of range");
    end

    // ***************************************************************
    // types and state
    // ***************************************************************
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,   // waiting for request
        BUS_ACK  = 2'b01,   // answering, waitrequest low
        BUS_DONE = 2'b10    // master releases request
    } pbm_bus_type;

    pbm_bus_type bus_reg;           // bus handshake state
    pbm_bus_type bus_next;
    logic [31:0] rdata_reg;         // read data to master
    logic [31:0] rdata_next;
    logic        wait_reg;          // waitrequest
    logic        wait_next;
    logic        loop_reg;          // loopback bit
    logic        loop_next;
    logic        speed_reg;         // speed select bit
    logic        speed_next;
    logic        an_reg;            // auto-negotiation enable bit
    logic        an_next;
    logic        dup_reg;           // duplex bit
    logic        dup_next;
    logic        srst_reg;          // software reset in progress
    logic        srst_next;
    logic [15:0] srst_cnt_reg;      // reset length counter
    logic [15:0] srst_cnt_next;
    logic [15:0] dead_cnt_reg;      // loopback dead time counter
    logic [15:0] dead_cnt_next;
    logic        dead_reg;          // dead time flag to the pin
    logic        dead_next;
    logic        spd_out_reg;       // effective speed
    logic        spd_out_next;
    logic        dup_out_reg;       // effective duplex
    logic        dup_out_next;
    logic        read_ev;           // event word read pulse
    logic [15:0] mode_word;         // readable control word

    pbm_bus_if   ev_bus ();

    // strap value for auto-negotiation enable; fiber overrides it
    function automatic logic an_strap(input logic strap, input logic fx);
        an_strap = strap & ~fx;
    endfunction

    // ***************************************************************
    // event latch instance
    // ***************************************************************
    pbm_event_latch u_events (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .ev_level_i (ev_level_i),
        .ev_count_i (ev_count_i),
        .ev_low_i   (ev_low_i),
        .ev_high_i  (ev_high_i),
        .bus        (ev_bus.latch)
    );

    // read of event word clears sticky bits, once per access
    assign read_ev = (bus_reg == BUS_IDLE) && avs_read_i &&
                     (avs_address_i == pbm_pkg::ADDR_EVENTS);
    assign ev_bus.read_events = read_ev;

    // assembled control word, reserved bits zero
    always_comb begin
        mode_word = 16'h0000;
        mode_word[pbm_pkg::BIT_RESET]    = srst_reg;
        mode_word[pbm_pkg::BIT_LOOPBACK] = loop_reg;
        mode_word[pbm_pkg::BIT_SPEED]    = speed_reg;
        mode_word[pbm_pkg::BIT_AN_EN]    = an_reg;
        mode_word[pbm_pkg::BIT_DUPLEX]   = dup_reg;
    end

    // ***************************************************************
    // bus slave: one wait cycle, then waitrequest low for one cycle
    // ***************************************************************
    always_comb begin
        bus_next   = bus_reg;
        rdata_next = rdata_reg;
        wait_next  = wait_reg;
        unique case (bus_reg)
            BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    bus_next  = BUS_ACK;
                    wait_next = 1'b0;
                    // unmapped addresses read zero
                    rdata_next = {16'h0000, pbm_pkg::READ_ZERO};
                    if (avs_address_i == pbm_pkg::ADDR_MODE_CTRL) begin
                        rdata_next = {16'h0000, mode_word};
                    end else if (avs_address_i == pbm_pkg::ADDR_EVENTS) begin
                        rdata_next = {27'h0000000, ev_bus.event_word};
                    end else if (avs_address_i == pbm_pkg::ADDR_STATE) begin
                        rdata_next = {28'h0000000, loop_dead_o,
                                      an_enable_o, full_duplex_o,
                                      speed_100_o};
                    end
                end
            end
            BUS_ACK: begin
                bus_next  = BUS_DONE;
                wait_next = 1'b1;
            end
            BUS_DONE: begin
                bus_next = BUS_IDLE;
            end
            default: begin
                bus_next  = BUS_IDLE;
                wait_next = 1'b1;
            end
        endcase
    end

    // write strobe taken at the acknowledge edge
    logic wr_ctrl;
    assign wr_ctrl = (bus_reg == BUS_ACK) && avs_write_i &&
                     (avs_address_i == pbm_pkg::ADDR_MODE_CTRL);

    // ***************************************************************
    // control register next values
    // ***************************************************************
    always_comb begin
        loop_next     = loop_reg;
        speed_next    = speed_reg;
        an_next       = an_reg;
        dup_next      = dup_reg;
        srst_next     = srst_reg;
        srst_cnt_next = srst_cnt_reg;
        dead_cnt_next = dead_cnt_reg;
        // count down first so a fresh enable can restart the window
        if (dead_cnt_reg != 16'h0000) begin
            dead_cnt_next = dead_cnt_reg - 16'h0001;
        end
        if (wr_ctrl) begin
            loop_next  = avs_writedata_i[pbm_pkg::BIT_LOOPBACK];
            speed_next = avs_writedata_i[pbm_pkg::BIT_SPEED];
            an_next    = avs_writedata_i[pbm_pkg::BIT_AN_EN];
            dup_next   = avs_writedata_i[pbm_pkg::BIT_DUPLEX];
            if (avs_writedata_i[pbm_pkg::BIT_RESET]) begin
                srst_next     = 1'b1;
                srst_cnt_next = 16'(RST_CYCLES);
            end
            if (avs_writedata_i[pbm_pkg::BIT_LOOPBACK] && !loop_reg) begin
                dead_cnt_next = 16'(LOOP_DEAD_CYCLES);
            end
        end
        if (srst_reg) begin
            if (srst_cnt_reg > 16'h0001) begin
                srst_cnt_next = srst_cnt_reg - 16'h0001;
            end else begin
                srst_next     = 1'b0;
                srst_cnt_next = 16'h0000;
                loop_next     = 1'b0;
                dead_cnt_next = 16'h0000;
                speed_next    = strap_speed_i;
                an_next       = an_strap(strap_an_en_i,
                                         fiber_mode_enable_i);
                dup_next      = strap_duplex_i;
            end
        end
        spd_out_next = an_reg ? spd_out_reg : speed_reg;
        dup_out_next = an_reg ? dup_out_reg : dup_reg;
        if (!an_reg) begin
            dup_out_next = dup_reg;
        end
        // flag registered so the pin comes from a flip-flop
        dead_next = (dead_cnt_next != 16'h0000);
    end

    // ***************************************************************
    // registers; straps caught on the first edge after release
    // ***************************************************************
    logic boot_reg;   // strap capture pending
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_reg      <= BUS_IDLE;
            rdata_reg    <= 32'h00000000;
            wait_reg     <= 1'b1;
            loop_reg     <= 1'b0;
            speed_reg    <= 1'b0;
            an_reg       <= 1'b0;
            dup_reg      <= 1'b0;
            srst_reg     <= 1'b0;
            srst_cnt_reg <= 16'h0000;
            dead_cnt_reg <= 16'h0000;
            dead_reg     <= 1'b0;
            spd_out_reg  <= 1'b0;
            dup_out_reg  <= 1'b0;
            boot_reg     <= 1'b1;
        end else begin
            bus_reg      <= bus_next;
            rdata_reg    <= rdata_next;
            wait_reg     <= wait_next;
            srst_reg     <= srst_next;
            srst_cnt_reg <= srst_cnt_next;
            dead_cnt_reg <= dead_cnt_next;
            dead_reg     <= dead_next;
            spd_out_reg  <= spd_out_next;
            dup_out_reg  <= dup_out_next;
            boot_reg     <= 1'b0;
            loop_reg     <= loop_next;
            if (boot_reg) begin
                speed_reg <= strap_speed_i;
                an_reg    <= an_strap(strap_an_en_i, fiber_mode_enable_i);
                dup_reg   <= strap_duplex_i;
            end else begin
                speed_reg <= speed_next;
                an_reg    <= an_next;
                dup_reg   <= dup_next;
            end
        end
    end

    // ***************************************************************
    // outputs, all from flip-flops
    // ***************************************************************
    assign avs_readdata_o    = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign loopback_o        = loop_reg;
    assign speed_100_o       = spd_out_reg;
    assign full_duplex_o     = dup_out_reg;
    assign an_enable_o       = an_reg;
    assign soft_reset_o      = srst_reg;
    assign loop_dead_o       = dead_reg;
endmodule

// file: verif/pbm_mode_ctrl_chk.sv
// assertions on the ports of the mode control bank
// assumes one clock domain and the bank's one-wait bus answer
`timescale 1ns/1ps
module pbm_mode_ctrl_chk #(
    parameter int RST_CYCLES       = 40,
    parameter int LOOP_DEAD_CYCLES = 10
) (
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        rst_i,
    // avalon-mm
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // straps
    input wire logic        strap_an_en_i,
    input wire logic        fiber_mode_enable_i,
    // port control
    input wire logic        loopback_o,
    input wire logic        speed_100_o,
    input wire logic        full_duplex_o,
    input wire logic        an_enable_o,
    input wire logic        soft_reset_o,
    input wire logic        loop_dead_o
);
    // ***************************************************
    // helpers
    // ***************************************************
    logic wr_mc;     // accepted write to mode control
    logic wr_plain;  // such a write, no reset involved
    int   srst_reg;  // cycles the soft reset has stood
    int   srst_next;
    assign wr_mc = avs_write_i && !avs_waitrequest_o
                   && avs_address_i == pbm_pkg::ADDR_MODE_CTRL;
    assign wr_plain = wr_mc && !avs_writedata_i[15] && !soft_reset_o;
    // run length of soft reset
    always_comb begin
        srst_next = soft_reset_o ? srst_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            srst_reg <= 32'h0;
        end else begin
            srst_reg <= srst_next;
        end
    end
    // ***************************************************
    // assertions
    // ***************************************************
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence req_rise;
        $rose(avs_read_i || avs_write_i);
    endsequence
    sequence one_wait;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    wait_one_a: assert property (req_rise |=> one_wait)
        else $error("bus answer not one wait cycle");
    reset_start_a: assert property (
        wr_mc && avs_writedata_i[15] |=> soft_reset_o)
        else $error("soft reset did not start");
    reset_len_a: assert property (
        soft_reset_o |-> srst_reg < RST_CYCLES)
        else $error("soft reset too long");
    reset_end_a: assert property (
        $fell(soft_reset_o) |-> srst_reg == RST_CYCLES)
        else $error("soft reset length wrong");
    reset_reload_a: assert property (
        $fell(soft_reset_o) |-> ##[0:2] (!loopback_o && an_enable_o
            == (strap_an_en_i && !fiber_mode_enable_i)))
        else $error("straps not reloaded");
    zero_noop_a: assert property (
        wr_plain |=> !soft_reset_o)
        else $error("zero write started reset");
    loop_follow_a: assert property (
        wr_plain |=> loopback_o == $past(avs_writedata_i[14]))
        else $error("loopback not as written");
    dead_start_a: assert property (
        $rose(loopback_o) |-> ##[0:1] loop_dead_o)
        else $error("dead time not started");
    manual_speed_a: assert property (
        wr_plain && !avs_writedata_i[12] && !an_enable_o |=> ##1
        (speed_100_o == $past(avs_writedata_i[13], 2)
         && full_duplex_o == $past(avs_writedata_i[8], 2)))
        else $error("manual speed or duplex wrong");
    an_hold_a: assert property (
        an_enable_o && $past(an_enable_o) && $past(an_enable_o, 2)
        |-> $stable(speed_100_o) && $stable(full_duplex_o))
        else $error("speed changed under negotiation");
    fixed_bit_a: assert property (
        avs_read_i && !avs_waitrequest_o && avs_address_i
        == pbm_pkg::ADDR_EVENTS |-> avs_readdata_o[4])
        else $error("fixed bit not set");
endmodule
bind pbm_mode_ctrl pbm_mode_ctrl_chk #(
    .RST_CYCLES(RST_CYCLES), .LOOP_DEAD_CYCLES(LOOP_DEAD_CYCLES)
) u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .strap_an_en_i(strap_an_en_i),
    .fiber_mode_enable_i(fiber_mode_enable_i), .loopback_o(loopback_o),
    .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o),
    .an_enable_o(an_enable_o), .soft_reset_o(soft_reset_o),
    .loop_dead_o(loop_dead_o));

// file: verif/pbm_mgmt_model.sv
// management station model: avalon-mm master of the bank
// assumes a slave that answers by dropping waitrequest
`timescale 1ns/1ps
module pbm_mgmt_model (
    // clock
    input  wire logic        mclk_i,
    // slave answer
    input  wire logic        waitrequest_i,
    input  wire logic [31:0] readdata_i,
    // master request
    output logic      [3:0]  address_o,
    output logic             read_o,
    output logic             write_o,
    output logic      [31:0] writedata_o
);
    initial begin
        address_o   = 4'h0;
        read_o      = 1'b0;
        write_o     = 1'b0;
        writedata_o = 32'h0000_0000;
    end
    // one transfer; ok stays low if the slave never answers
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic ok);
        int n;
        n = 0;
        @(posedge mclk_i);
        address_o   <= a;
        writedata_o <= d;
        write_o     <= w;
        read_o      <= !w;
        // hold everything until waitrequest is seen low
        do begin
            @(posedge mclk_i);
            n++;
        end while (waitrequest_i !== 1'b0 && n < 64);
        q  = readdata_i;
        ok = (waitrequest_i === 1'b0);
        read_o  <= 1'b0;
        write_o <= 1'b0;
        // released lines show no stale value
        address_o   <= ~a;
        writedata_o <= ~d;
    endtask
endmodule

// file: verif/test_phy_basic_mode_control.sv
// self-checking bench of the mode control bank
// assumes the management model drives the avalon side
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    mismatches++; $display("FAIL %0t got %h exp %h", $time, got, exp); \
    end end
module test_phy_basic_mode_control;
    localparam int DC = 10;                 // shortened dead time
    localparam logic [15:0] MASK = 16'hF100; // bits with known values
    logic        mclk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic        strap_speed_i, strap_an_en_i, strap_duplex_i;
    logic        fiber_mode_enable_i, ev_level_i, ev_count_i;
    logic        ev_low_i, ev_high_i, loopback_o, speed_100_o;
    logic        full_duplex_o, an_enable_o, soft_reset_o, loop_dead_o;
    int          mismatches, n_compared;
    pbm_mode_ctrl #(.RST_CYCLES(40), .LOOP_DEAD_CYCLES(DC)) dut (
        .mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
        .strap_speed_i, .strap_an_en_i, .strap_duplex_i,
        .fiber_mode_enable_i, .ev_level_i, .ev_count_i, .ev_low_i,
        .ev_high_i, .loopback_o, .speed_100_o, .full_duplex_o,
        .an_enable_o, .soft_reset_o, .loop_dead_o);
    pbm_mgmt_model mgmt (.mclk_i, .waitrequest_i(avs_waitrequest_o),
        .readdata_i(avs_readdata_o), .address_o(avs_address_i),
        .read_o(avs_read_i), .write_o(avs_write_i),
        .writedata_o(avs_writedata_i));
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // bus access; a hung slave ends the run
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [15:0] d, output logic [15:0] r);
        logic [31:0] q;
        logic        ok;
        mgmt.xfer(w, a, {16'h0000, d}, q, ok);
        r = q[15:0];
        if (!ok) begin
            mismatches++;
            $display("FAIL %0t bus hang", $time);
            end_sim();
        end
        if (!w) `CHK(q[31:16], 16'h0000)
    endtask
    function automatic logic [15:0] mc(input logic r, l, s, a, u);
        mc = 16'h0000;
        mc[pbm_pkg::BIT_RESET]    = r;
        mc[pbm_pkg::BIT_LOOPBACK] = l;
        mc[pbm_pkg::BIT_SPEED]    = s;
        mc[pbm_pkg::BIT_AN_EN]    = a;
        mc[pbm_pkg::BIT_DUPLEX]   = u;
    endfunction
    // event word, fixed bit always one
    function automatic logic [4:0] ev(input logic s, c, z, o);
        ev = {1'b1, o, z, c, s};
    endfunction
    task automatic t_straps();
        logic [15:0] q;
        acc(0, pbm_pkg::ADDR_MODE_CTRL, 0, q);
        `CHK(q & MASK, mc(0, 0, 1, 0, 1))
    endtask
    task automatic t_events();
        logic [15:0] q;
        acc(0, pbm_pkg::ADDR_EVENTS, 0, q);
        `CHK(q[4:0], ev(0, 0, 1, 0))
        {ev_level_i, ev_count_i, ev_low_i, ev_high_i} <= 4'hF;
        tick(1);
        {ev_count_i, ev_low_i, ev_high_i} <= 3'h0;
        tick(4);
        acc(0, pbm_pkg::ADDR_EVENTS, 0, q);
        `CHK(q[4:0], ev(1, 1, 0, 1))
        ev_level_i <= 1'b0;
        acc(1, pbm_pkg::ADDR_EVENTS, 16'h0000, q);
        tick(2);
        acc(0, pbm_pkg::ADDR_EVENTS, 0, q);
        `CHK(q[4:0], ev(0, 0, 1, 0))
    endtask
    task automatic t_manual();
        logic [15:0] q;
        for (int i = 0; i < 4; i++) begin
            acc(1, pbm_pkg::ADDR_MODE_CTRL, mc(0, 0, i[1], 0, i[0]), q);
            acc(0, pbm_pkg::ADDR_MODE_CTRL, 0, q);
            `CHK(q & MASK, mc(0, 0, i[1], 0, i[0]))
            `CHK({speed_100_o, full_duplex_o}, 2'(i))
        end
        // speed and duplex bits written zero are ignored while negotiation runs
        acc(1, pbm_pkg::ADDR_MODE_CTRL, mc(0, 0, 0, 1, 0), q);
        tick(3);
        `CHK({an_enable_o, full_duplex_o, speed_100_o}, 3'h7)
    endtask
    task automatic t_loop();
        logic [15:0] q;
        acc(1, pbm_pkg::ADDR_MODE_CTRL, mc(0, 1, 0, 0, 0), q);
        tick(2);
        `CHK({loopback_o, loop_dead_o}, 2'h3)
        tick(DC + 2);
        `CHK(loop_dead_o, 1'b0)
    endtask
    task automatic t_soft();
        logic [15:0] q;
        int          n;
        {strap_speed_i, strap_an_en_i, fiber_mode_enable_i} <= 3'h2;
        acc(1, pbm_pkg::ADDR_MODE_CTRL, mc(0, 0, 0, 0, 0), q);
        tick(1);
        `CHK({soft_reset_o, loopback_o}, 2'h0)
        acc(1, pbm_pkg::ADDR_MODE_CTRL, mc(1, 0, 1, 0, 0), q);
        acc(0, pbm_pkg::ADDR_MODE_CTRL, 0, q);
        `CHK(q[15], 1'b1)
        acc(1, pbm_pkg::ADDR_MODE_CTRL, mc(0, 1, 1, 0, 0), q);
        acc(0, pbm_pkg::ADDR_MODE_CTRL, 0, q);
        `CHK(q[15], 1'b1)
        n = 0;
        while (soft_reset_o !== 1'b0 && n < 100) begin
            tick(1);
            n++;
        end
        `CHK(soft_reset_o, 1'b0)
        tick(3);
        acc(0, pbm_pkg::ADDR_MODE_CTRL, 0, q);
        `CHK(q & MASK, mc(0, 0, 0, 1, 1))
        `CHK({an_enable_o, loopback_o}, 2'h2)
    endtask
    task automatic t_map();
        logic [15:0] q;
        acc(1, 4'h7, 16'hFFFF, q);
        acc(0, 4'h7, 0, q);
        `CHK(q, 16'h0000)
        acc(0, pbm_pkg::ADDR_STATE, 0, q);
        `CHK(q[3:2], 2'h1)
    endtask
    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        mismatches = 0;
        n_compared = 0;
        rst_i = 1'b1;
        {strap_speed_i, strap_an_en_i, strap_duplex_i} = 3'h7;
        fiber_mode_enable_i = 1'b1;
        {ev_level_i, ev_count_i, ev_low_i, ev_high_i} = 4'h0;
        tick(16);
        rst_i <= 1'b0;
        tick(2);
        t_straps();
        t_events();
        t_manual();
        t_loop();
        t_soft();
        t_map();
        end_sim();
    end
endmodule
